// >>> common/lss_pkg.sv
// Package: constants and carrier types for the LED sink shift/latch block
package lss_pkg;
	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int WORD_W = 8;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] SINK_OFF = 8'h00;
	localparam logic [1:0] SYNC_RST = 2'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SYNC_STAGES = 2;
	// Pin edge to state change: two sync flops plus the state register that updates
	localparam int PIN_LAT_CYC = SYNC_STAGES + 1;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic shift_clk;
		logic serial_in;
		logic load_strobe;
		logic out_en_b;
		logic over_temp;
		logic cool;
	} lss_pins_type;

	typedef struct packed {
		logic [7:0] sink_on;
		logic [7:0] sink_oe;
	} lss_sink_type;
endpackage

// >>> hw/lss_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
module lss_sync #(
	parameter int W = 6
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Async in, synced out
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// First stage feeds only the second stage
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule

// >>> hw/lss_top.sv
// Eight-channel LED sink driver: shift register, latch, output gating
`timescale 1ns/1ps
module lss_top (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Serial link pins (asynchronous)
	input wire logic i_shift_clk,
	input wire logic i_serial_in,
	input wire logic i_load_strobe,
	input wire logic i_out_en_b,
	// Thermal sensor levels (asynchronous)
	input wire logic i_over_temp,
	input wire logic i_cool,
	// Serial output and sinks
	output logic o_serial_out,
	output logic [7:0] o_sink_on,
	output logic [7:0] o_sink_oe,
	// Observation of internal state
	output logic [7:0] o_shift_word,
	output logic [7:0] o_latch_word
);
	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	lss_pkg::lss_pins_type pins_async;
	lss_pkg::lss_pins_type pins;
	lss_pkg::lss_sink_type sink;

	assign pins_async = '{shift_clk: i_shift_clk, serial_in: i_serial_in,
		load_strobe: i_load_strobe, out_en_b: i_out_en_b,
		over_temp: i_over_temp, cool: i_cool};

	lss_sync #(
		.W($bits(lss_pkg::lss_pins_type))
	) u_sync (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_async(pins_async),
		.o_sync(pins)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic sclk_d_reg;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [7:0] latch_reg;
	logic [7:0] latch_next;
	logic hot_reg;
	logic hot_next;
	logic [7:0] sink_on_reg;
	logic [7:0] sink_oe_reg;
	logic [7:0] sink_on_next;
	logic [7:0] sink_oe_next;
	logic [1:0] fill_reg;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire sclk_rise = pins.shift_clk && !sclk_d_reg;
	// Input enters bit 0 and ripples toward bit 7, the serial output
	assign shift_next = sclk_rise ? {shift_reg[6:0], pins.serial_in}
		: shift_reg;
	// Transparent while high; holding the last followed value at the fall
	// is the capture, so no separate edge logic is needed
	assign latch_next = pins.load_strobe ? shift_reg : latch_reg;
	// Hysteresis: hot sets on over-temp, clears only on cool
	assign hot_next = pins.over_temp ? 1'b1
		: (pins.cool ? 1'b0 : hot_reg);
	// Sync flops reset to zero, which reads as enabled; sinks stay off
	// until the flops hold real pin levels
	wire sync_live = fill_reg[1];
	wire drive_en = sync_live && !pins.out_en_b && !hot_reg;

	// Per-sink gating, one entry per channel
	genvar g;
	generate
		for (g = 0; g < lss_pkg::WORD_W; g++) begin : g_sink
			// Sink n follows latch bit n; a one pulls the LED on
			assign sink_on_next[g] = drive_en & latch_reg[g];
			assign sink_oe_next[g] = drive_en;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Enable and thermal state do not enter shift or latch paths
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			sclk_d_reg <= 1'b0;
			shift_reg <= lss_pkg::SHIFT_RST;
			latch_reg <= lss_pkg::LATCH_RST;
		end else begin
			sclk_d_reg <= pins.shift_clk;
			shift_reg <= shift_next;
			latch_reg <= latch_next;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			hot_reg <= 1'b0;
			fill_reg <= lss_pkg::SYNC_RST;
			sink_on_reg <= lss_pkg::SINK_OFF;
			sink_oe_reg <= lss_pkg::SINK_OFF;
		end else begin
			hot_reg <= hot_next;
			fill_reg <= {fill_reg[0], 1'b1};
			sink_on_reg <= sink_on_next;
			sink_oe_reg <= sink_oe_next;
		end
	end

	assign sink = '{sink_on: sink_on_reg, sink_oe: sink_oe_reg};
	assign o_sink_on = sink.sink_on;
	assign o_sink_oe = sink.sink_oe;
	assign o_serial_out = shift_reg[7];
	assign o_shift_word = shift_reg;
	assign o_latch_word = latch_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_shift;
		@(posedge i_mclk) disable iff (!i_rst_b)
		sclk_rise |=> shift_reg == {$past(shift_reg[6:0]),
			$past(pins.serial_in)};
	endproperty
	a_shift: assert property (p_shift)
		else $error("shift register did not advance on clock rise");

	property p_hold;
		@(posedge i_mclk) disable iff (!i_rst_b)
		!sclk_rise |=> $stable(shift_reg);
	endproperty
	a_hold: assert property (p_hold)
		else $error("shift register changed without clock rise");

	property p_dout;
		@(posedge i_mclk) disable iff (!i_rst_b)
		sclk_rise |=> o_serial_out == $past(shift_reg[6]);
	endproperty
	a_dout: assert property (p_dout)
		else $error("serial output not last stage");

	property p_transp;
		@(posedge i_mclk) disable iff (!i_rst_b)
		pins.load_strobe |=> latch_reg == $past(shift_reg);
	endproperty
	a_transp: assert property (p_transp)
		else $error("latch not transparent while strobe high");

	property p_latched;
		@(posedge i_mclk) disable iff (!i_rst_b)
		!pins.load_strobe |=> $stable(latch_reg);
	endproperty
	a_latched: assert property (p_latched)
		else $error("latch changed while strobe low");

	property p_blank;
		@(posedge i_mclk) disable iff (!i_rst_b)
		pins.out_en_b |=> o_sink_oe == 8'h00 && o_sink_on == 8'h00;
	endproperty
	a_blank: assert property (p_blank)
		else $error("sinks driven while enable high");

	property p_follow;
		@(posedge i_mclk) disable iff (!i_rst_b)
		sync_live && !pins.out_en_b && !hot_reg |=> o_sink_oe == 8'hFF
			&& o_sink_on == $past(latch_reg);
	endproperty
	a_follow: assert property (p_follow)
		else $error("sinks do not follow latch");

	property p_hot;
		@(posedge i_mclk) disable iff (!i_rst_b)
		pins.over_temp |=> ##1 o_sink_on == 8'h00 && o_sink_oe == 8'h00;
	endproperty
	a_hot: assert property (p_hot)
		else $error("sinks on during over-temperature");

	property p_hot_keep;
		@(posedge i_mclk) disable iff (!i_rst_b)
		hot_reg && !pins.load_strobe && !sclk_rise |=>
			$stable(latch_reg) && $stable(shift_reg);
	endproperty
	a_hot_keep: assert property (p_hot_keep)
		else $error("thermal state disturbed register or latch");

	c_shift: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		sclk_rise);
	c_load: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		pins.load_strobe ##1 !pins.load_strobe);
	c_hot: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		hot_reg ##1 !hot_reg);
	c_lit: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
		o_sink_on != 8'h00);
endmodule

// >>> sim/lss_host.sv
// Host controller model driving the serial link pins
`timescale 1ns/1ps
module lss_host (
	// Clock
	input wire logic i_mclk,
	// Link pins
	output logic o_shift_clk,
	output logic o_serial_in,
	output logic o_load_strobe
);
	initial begin
		o_shift_clk = 1'b0;
		o_serial_in = 1'b0;
		o_load_strobe = 1'b0;
	end
	// Data set while the clock is low, held past the rise
	// One bit is eight clock cycles, a 400 ns shift clock period
	task automatic send_bit(input logic b);
		o_serial_in = b;
		repeat (4) @(negedge i_mclk);
		o_shift_clk = 1'b1;
		repeat (2) @(negedge i_mclk);
		// Released data shows the inverse, never a stale copy
		o_serial_in = ~b;
		repeat (2) @(negedge i_mclk);
		o_shift_clk = 1'b0;
	endtask
	task automatic set_strobe(input logic lvl);
		@(negedge i_mclk);
		o_load_strobe = lvl;
	endtask
endmodule

// >>> sim/lss_top_test.sv
// Self-checking bench for the LED sink shift/latch block
`timescale 1ns/1ps
module lss_top_test;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic out_en_b = 1'b1;
	logic over_temp = 1'b0;
	logic cool = 1'b0;
	logic shift_clk, serial_in, load_strobe, serial_out;
	logic [7:0] sink_on, sink_oe, shift_word, latch_word;
	logic [7:0] exp_shift = 8'h00;
	logic [7:0] chain_word;
	int errors = 0;
	int check_count = 0;
	always #25 mclk = ~mclk;
	lss_host host_u (.i_mclk(mclk), .o_shift_clk(shift_clk),
		.o_serial_in(serial_in), .o_load_strobe(load_strobe));
	lss_top dut_u (.i_mclk(mclk), .i_rst_b(rst_b),
		.i_shift_clk(shift_clk), .i_serial_in(serial_in),
		.i_load_strobe(load_strobe), .i_out_en_b(out_en_b),
		.i_over_temp(over_temp), .i_cool(cool),
		.o_serial_out(serial_out), .o_sink_on(sink_on),
		.o_sink_oe(sink_oe), .o_shift_word(shift_word),
		.o_latch_word(latch_word));
	// Second driver fed from the first one's serial output
	lss_top dut_chain_u (.i_mclk(mclk), .i_rst_b(rst_b),
		.i_shift_clk(shift_clk), .i_serial_in(serial_out),
		.i_load_strobe(load_strobe), .i_out_en_b(out_en_b),
		.i_over_temp(over_temp), .i_cool(cool),
		.o_serial_out(), .o_sink_on(), .o_sink_oe(),
		.o_shift_word(chain_word), .o_latch_word());
	task automatic check(input string what, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic send_word(input logic [7:0] w);
		for (int i = 7; i >= 0; i--) begin
			host_u.send_bit(w[i]);
			exp_shift = {exp_shift[6:0], w[i]};
			check("serial out", {7'h00, exp_shift[7]}, {7'h00, serial_out});
		end
		check("shift word", exp_shift, shift_word);
	endtask
	task automatic t_shift();
		send_word(8'hA5);
		send_word(8'h3C);
		check("chain word", 8'hA5, chain_word);
		$display("test shift done");
	endtask
	// Enable held high here, so latching is seen with sinks blanked
	task automatic t_latch();
		host_u.set_strobe(1'b1);
		send_word(8'h5A);
		check("latch open", 8'h5A, latch_word);
		check("blanked", 8'h00, sink_oe);
		host_u.set_strobe(1'b0);
		idle(4);
		send_word(8'h81);
		check("latch held", 8'h5A, latch_word);
		host_u.set_strobe(1'b1);
		idle(6);
		host_u.set_strobe(1'b0);
		idle(4);
		check("latch loaded", 8'h81, latch_word);
		$display("test latch done");
	endtask
	task automatic t_enable();
		for (int k = 0; k < 3; k++) begin
			out_en_b = 1'b0;
			idle(6);
			check("sink oe", 8'hFF, sink_oe);
			check("sink on", 8'h81, sink_on);
			out_en_b = 1'b1;
			idle(6);
			check("sink oe off", 8'h00, sink_oe);
			check("sink on off", 8'h00, sink_on);
			check("latch kept", 8'h81, latch_word);
		end
		out_en_b = 1'b0;
		$display("test enable done");
	endtask
	task automatic t_thermal();
		idle(6);
		check("lit before hot", 8'h81, sink_on);
		over_temp = 1'b1;
		idle(6);
		check("hot off", 8'h00, sink_on);
		over_temp = 1'b0;
		idle(6);
		check("still off", 8'h00, sink_on);
		cool = 1'b1;
		idle(6);
		check("resumed", 8'h81, sink_on);
		check("shift kept", exp_shift, shift_word);
		check("latch kept hot", 8'h81, latch_word);
		cool = 1'b0;
		$display("test thermal done");
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		tally_and_finish();
	end
	initial begin
		idle(6);
		rst_b = 1'b1;
		idle(3);
		check("reset shift", 8'h00, shift_word);
		check("reset sinks", 8'h00, sink_on);
		$display("test reset done");
		t_shift();
		t_latch();
		t_enable();
		t_thermal();
		tally_and_finish();
	end
endmodule
